// File: logic/drive_param_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts for
 * the drive parameter store. Definitions only; included by bare name.
 * Assumes a 16-bit register port with 8-bit word addresses.
 */
`ifndef DRIVE_PARAM_REGS_VH
`define DRIVE_PARAM_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word addresses)
// ----------------------------------------------------------------
`define OFS_VIEW_A 8'h00
`define OFS_VIEW_B 8'h01
`define OFS_SEL_ONE 8'h02
`define OFS_SEL_ONE_SRC 8'h03
`define OFS_SEL_TWO 8'h04
`define OFS_SEL_TWO_SRC 8'h05
`define OFS_RUN_HOURS 8'h06
`define OFS_KEY_LEVEL 8'h07
`define OFS_LIST_FILTER 8'h08
`define OFS_NV_CTRL 8'h09
`define OFS_EDIT_SET 8'h0a
`define OFS_COPY_CMD 8'h0b
`define OFS_ACTIVE_SET 8'h0c
`define OFS_NV_COUNT 8'h0d
`define OFS_STATUS 8'h0e
`define OFS_FAULT_BASE 4'h1
`define OFS_SETPAR_BASE 4'h2

// ----------------------------------------------------------------
// Reset values and ranges
// ----------------------------------------------------------------
`define RST_SOURCE 9'h000
`define RST_KEY 6'h00
`define RST_FILTER 2'h3
`define RST_NV_CTRL 5'h0b
`define RST_EDIT_SET 3'h1
`define RST_COPY_CMD 8'h0c
`define SOURCE_MAX 16'h018f
`define KEY_MAX 16'h0028
`define COPY_MIN 16'h000b
`define COPY_MAX 16'h00f4
`define FILTER_MAX 16'h0003

// ----------------------------------------------------------------
// Access levels granted by the key and function trigger codes
// ----------------------------------------------------------------
`define LVL_OPER 6'h0a
`define LVL_TECH 6'h14
`define LVL_SERV 6'h1e
`define LVL_AUTH 6'h28
`define FN_OUT_LO 6'h0b
`define FN_OUT_HI 6'h13
`define FN_ACT_LO 6'h15
`define FN_ACT_HI 6'h1c

// ----------------------------------------------------------------
// Display scaling and status bits
// ----------------------------------------------------------------
`define DISP_FULL 16'sd10000
`define DISP_MAX 32'sd19999
`define DISP_MIN -32'sd20000
`define ST_PARAM_SAVE 0
`define ST_PROC_SAVE 1
`define ST_JUMPER 2
`define ST_COPY_BUSY 3
`define ST_REFUSED 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_NS 100
`define RUN_TENTH_NS 100000000
`define TENTHS_PER_HOUR 16'd36000
`define HOURS_MAX 16'hffff

`endif

// File: logic/param_set_store.v
/*
 * Four parameter sets of sixteen words each, with an editing port, a
 * read port for the set in use, and a copy/interchange engine.
 * Assumes the caller never edits while the copy engine is busy.
 */
`timescale 1ns/1ns
module param_set_store (
    input wire clock,
    input wire reset_n,
    input wire [1:0] edit_set,
    input wire [3:0] edit_idx,
    input wire edit_wr,
    input wire [15:0] edit_wdata,
    output wire [15:0] edit_rdata,
    input wire [1:0] use_set,
    input wire [3:0] use_idx,
    output wire [15:0] use_rdata,
    input wire copy_start,
    input wire copy_swap,
    input wire [1:0] copy_src,
    input wire [1:0] copy_dst,
    output reg copy_busy
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [15:0] mem [0:63]; // Set number in the top two index bits
    reg [3:0] walk; // Word being copied
    reg swap; // Interchange rather than copy
    reg [1:0] src; // Latched source set
    reg [1:0] dst; // Latched destination set

    assign edit_rdata = mem[{edit_set, edit_idx}];
    assign use_rdata = mem[{use_set, use_idx}];

    // Engine control: one word pair per cycle, sixteen cycles
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            copy_busy <= 1'b0;
            walk <= 4'h0;
            swap <= 1'b0;
            src <= 2'h0;
            dst <= 2'h0;
        end else if (copy_busy) begin
            // Last word ends the run
            walk <= walk + 4'h1;
            if (walk == 4'hf) begin
                copy_busy <= 1'b0;
            end
        end else if (copy_start) begin
            copy_busy <= 1'b1;
            walk <= 4'h0;
            swap <= copy_swap;
            src <= copy_src;
            dst <= copy_dst;
        end
    end

    // Array writes; non-blocking reads give the old words for a swap
    always @(posedge clock) begin
        if (copy_busy) begin
            mem[{dst, walk}] <= mem[{src, walk}];
            if (swap) begin
                mem[{src, walk}] <= mem[{dst, walk}];
            end
        end else if (edit_wr) begin
            mem[{edit_set, edit_idx}] <= edit_wdata;
        end
    end
endmodule

// File: logic/drive_param_ctrl.v
/*
 * Parameter handling block of a DC drive: scaled connector displays,
 * fault diagnostic memory, running hours, key levels and function
 * triggers, permanent memory write control and four parameter sets.
 * Assumes all inputs are synchronous to clock and that the permanent
 * memory controller outside acts on the one-cycle write pulses.
 */
// The address-and-strobe port and the register offsets were decided locally.
// What this block does
// - Scale connector so 16384 shows 100.00 percent
// - Display in 0.01 percent, saturate -200.00..199.99
// - Selectors take 0..399, volatile, zero at power-up
// - Sixteen fault words, word 15 fault number
// - Count running hours to 65535 in tenths
// - Key 0,10,20,30,40 grant graded access levels
// - Keys 11-19 outputs, 21-28 actions trigger
// - Key always writable, 0..40, factory zero
// - List filter 0..3 selects visibility, default 3
// - Low digit one saves parameters permanently
// - High digit one saves process data permanently
// - Write-protect jumper blocks every permanent write
// - Control word 00..11, factory value 11
// - Count permanent writes; host limits write wear
// - Four sets; editing routed to selected set
// - Hundreds digit: 1 copy, 2 swap, 0 idle
// - Copy starts only offline; digit cleared after
// - Copy command volatile, 012 at start, 011..244
// - Read-only indicator of set in use, 1..4
`timescale 1ns/1ns
`include "drive_param_regs.vh"
module drive_param_ctrl #(
    parameter TENTH_CYCLES = `RUN_TENTH_NS / `CLOCK_NS
) (
    input wire clock,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [15:0] view_a_raw,
    input wire [15:0] view_b_raw,
    output reg [8:0] source_one,
    output reg [8:0] source_two,
    input wire [15:0] source_one_raw,
    input wire [15:0] source_two_raw,
    input wire fault_wr,
    input wire [3:0] fault_idx,
    input wire [15:0] fault_data,
    input wire running,
    input wire write_protect_jumper,
    input wire nv_param_req,
    input wire nv_proc_req,
    output reg nv_param_write,
    output reg nv_proc_write,
    output reg [1:0] list_filter,
    output reg [5:0] access_level,
    output reg func_req,
    output reg [5:0] func_code,
    input wire [1:0] set_inputs,
    input wire [3:0] use_idx,
    output reg [15:0] use_data
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [5:0] key_level; // Stored key value
    reg [4:0] nv_write_control; // Decimal 0, 1, 10 or 11
    reg [2:0] edit_set_select; // 1..4
    reg [7:0] set_copy_command; // Decimal 11..244
    reg [15:0] run_hours; // Whole hours
    reg [15:0] tenths; // Tenths within the hour
    reg [19:0] tick_count; // Cycles within the tenth
    reg [15:0] nv_write_count; // Granted permanent writes
    reg refused; // Last write was refused
    reg copy_go; // Start pulse to the engine
    reg copy_was_busy; // Engine busy last cycle
    reg [15:0] fault_diag_words [0:15]; // Diagnostic memory
    reg [15:0] next_rdata; // Read data before the flop
    reg wr_ok; // Write passes level and range
    wire copy_busy; // Engine running
    wire [15:0] edit_rdata; // Word of the edited set
    wire [15:0] use_rdata; // Word of the set in use
    wire [1:0] hund; // Operation digit of command
    wire [2:0] tens; // Source digit of command
    wire [2:0] ones; // Destination digit of command
    wire copy_ok; // Operation digit is copy or swap
    wire prot; // Permanent writes allowed at all
    wire set_par_wr; // Write into the edited set

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Scale raw connector to 0.01 percent units, clamped
    function [15:0] scale_disp;
        input [15:0] raw;
        reg signed [31:0] prod;
        begin
            prod = ($signed(raw) * `DISP_FULL) >>> 14;
            if (prod > `DISP_MAX) begin
                prod = `DISP_MAX;
            end else if (prod < `DISP_MIN) begin
                prod = `DISP_MIN;
            end
            scale_disp = prod[15:0];
        end
    endfunction

    // Grade of access a key value grants
    function [5:0] grade;
        input [5:0] key;
        begin
            if (key >= `LVL_AUTH) begin
                grade = `LVL_AUTH;
            end else if (key >= `LVL_SERV) begin
                grade = `LVL_SERV;
            end else if (key >= `LVL_TECH) begin
                grade = `LVL_TECH;
            end else if (key >= `LVL_OPER) begin
                grade = `LVL_OPER;
            end else begin
                grade = 6'h00;
            end
        end
    endfunction

    // Tens digit of a value below fifty; 40 to 99 all give 4
    function [2:0] tens_of;
        input [7:0] v;
        begin
            if (v >= 8'd40) begin
                tens_of = 3'd4;
            end else if (v >= 8'd30) begin
                tens_of = 3'd3;
            end else if (v >= 8'd20) begin
                tens_of = 3'd2;
            end else if (v >= 8'd10) begin
                tens_of = 3'd1;
            end else begin
                tens_of = 3'd0;
            end
        end
    endfunction

    // Decimal digits of a copy command word
    function [7:0] low_two;
        input [7:0] v;
        begin
            if (v >= 8'd200) begin
                low_two = v - 8'd200;
            end else if (v >= 8'd100) begin
                low_two = v - 8'd100;
            end else begin
                low_two = v;
            end
        end
    endfunction

    // Digits of the command checked on a write; a tens digit above 4
    // shows as 4 here and is caught by the ones check
    function cmd_valid;
        input [15:0] v;
        reg [7:0] r;
        reg [2:0] t;
        reg [7:0] o;
        begin
            r = low_two(v[7:0]);
            t = tens_of(r);
            o = r - {1'b0, t, 1'b0} * 8'd5;
            cmd_valid = (v >= `COPY_MIN) && (v <= `COPY_MAX) &&
                (t != 3'd0) && (o >= 8'd1) && (o <= 8'd4);
        end
    endfunction

    // ----------------------------------------------------------------
    // Decode of the stored copy command
    // ----------------------------------------------------------------
    assign hund = (set_copy_command >= 8'd200) ? 2'd2 :
        (set_copy_command >= 8'd100) ? 2'd1 : 2'd0;
    assign tens = tens_of(low_two(set_copy_command));
    wire [7:0] ones_w = low_two(set_copy_command) -
        {1'b0, tens, 1'b0} * 8'd5;
    assign ones = ones_w[2:0];
    assign copy_ok = (hund != 2'd0);
    assign prot = !write_protect_jumper;
    assign set_par_wr = reg_wr && wr_ok &&
        (reg_addr[7:4] == `OFS_SETPAR_BASE);

    // ----------------------------------------------------------------
    // Write acceptance: level and range per register
    // ----------------------------------------------------------------
    // Refused writes change nothing but the refused flag
    always @* begin
        wr_ok = 1'b0;
        case (reg_addr)
            `OFS_SEL_ONE_SRC, `OFS_SEL_TWO_SRC:
                wr_ok = (access_level >= `LVL_OPER) &&
                    (reg_wdata <= `SOURCE_MAX);
            `OFS_KEY_LEVEL:
                wr_ok = (reg_wdata <= `KEY_MAX);
            `OFS_LIST_FILTER:
                wr_ok = (access_level >= `LVL_OPER) &&
                    (reg_wdata <= `FILTER_MAX);
            `OFS_NV_CTRL:
                wr_ok = (access_level >= `LVL_TECH) &&
                    (reg_wdata == 16'd0 || reg_wdata == 16'd1 ||
                    reg_wdata == 16'd10 ||
                    reg_wdata == 16'd11);
            `OFS_EDIT_SET:
                wr_ok = (access_level >= `LVL_OPER) &&
                    (reg_wdata >= 16'd1) &&
                    (reg_wdata <= 16'd4);
            `OFS_COPY_CMD:
                wr_ok = (access_level >= `LVL_TECH) && !running &&
                    !copy_busy && cmd_valid(reg_wdata);
            default: begin
                // Set words need technical level and a quiet engine
                if (reg_addr[7:4] == `OFS_SETPAR_BASE) begin
                    wr_ok = (access_level >= `LVL_TECH) &&
                        !copy_busy;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Register writes and function triggers
    // ----------------------------------------------------------------
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            source_one <= `RST_SOURCE;
            source_two <= `RST_SOURCE;
            key_level <= `RST_KEY;
            access_level <= 6'h00;
            list_filter <= `RST_FILTER;
            nv_write_control <= `RST_NV_CTRL;
            edit_set_select <= `RST_EDIT_SET;
            set_copy_command <= `RST_COPY_CMD;
            refused <= 1'b0;
            func_req <= 1'b0;
            func_code <= 6'h00;
            copy_go <= 1'b0;
            copy_was_busy <= 1'b0;
        end else begin
            func_req <= 1'b0;
            copy_go <= 1'b0;
            copy_was_busy <= copy_busy;
            access_level <= grade(key_level);
            // Engine finished: clear the operation digit
            if (copy_was_busy && !copy_busy) begin
                set_copy_command <= low_two(set_copy_command);
            end
            if (reg_wr) begin
                refused <= !wr_ok;
            end
            if (reg_wr && wr_ok) begin
                case (reg_addr)
                    `OFS_SEL_ONE_SRC: source_one <= reg_wdata[8:0];
                    `OFS_SEL_TWO_SRC: source_two <= reg_wdata[8:0];
                    `OFS_KEY_LEVEL: begin
                        key_level <= reg_wdata[5:0];
                        // Trigger codes also raise a request pulse
                        if ((reg_wdata[5:0] >= `FN_OUT_LO &&
                            reg_wdata[5:0] <= `FN_OUT_HI) ||
                            (reg_wdata[5:0] >= `FN_ACT_LO &&
                            reg_wdata[5:0] <= `FN_ACT_HI)) begin
                            func_req <= 1'b1;
                            func_code <= reg_wdata[5:0];
                        end
                    end
                    `OFS_LIST_FILTER: list_filter <= reg_wdata[1:0];
                    `OFS_NV_CTRL: nv_write_control <= reg_wdata[4:0];
                    `OFS_EDIT_SET: edit_set_select <= reg_wdata[2:0];
                    `OFS_COPY_CMD: begin
                        set_copy_command <= reg_wdata[7:0];
                        // Operation digit non-zero: start the engine
                        copy_go <= (reg_wdata >= 16'd100);
                    end
                    default: begin
                        // Set words go straight to the store
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Permanent memory write gating and wear counter
    // ----------------------------------------------------------------
    // The control word itself is always saved unless the jumper is in
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            nv_param_write <= 1'b0;
            nv_proc_write <= 1'b0;
            nv_write_count <= 16'h0000;
        end else begin
            nv_param_write <= prot && ((nv_param_req &&
                nv_write_control[0]) ||
                (copy_was_busy && !copy_busy &&
                nv_write_control[0]) ||
                (reg_wr && wr_ok && reg_addr == `OFS_NV_CTRL));
            nv_proc_write <= prot && nv_proc_req &&
                (nv_write_control >= 5'd10);
            if ((nv_param_write || nv_proc_write) &&
                nv_write_count != 16'hffff) begin
                nv_write_count <= nv_write_count + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Running hours
    // ----------------------------------------------------------------
    // The cycle count is kept while stopped, so short runs add up
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_count <= 20'h00000;
            tenths <= 16'h0000;
            run_hours <= 16'h0000;
        end else if (running) begin
            if (tick_count == TENTH_CYCLES[19:0] - 20'h00001) begin
                tick_count <= 20'h00000;
                if (tenths == `TENTHS_PER_HOUR - 16'd1) begin
                    tenths <= 16'h0000;
                    if (run_hours != `HOURS_MAX) begin
                        run_hours <= run_hours + 16'h0001;
                    end
                end else begin
                    tenths <= tenths + 16'h0001;
                end
            end else begin
                tick_count <= tick_count + 20'h00001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault diagnostic memory
    // ----------------------------------------------------------------
    // Filled by the fault handler; word 15 carries the fault number
    always @(posedge clock) begin
        if (fault_wr) begin
            fault_diag_words[fault_idx] <= fault_data;
        end
    end

    // ----------------------------------------------------------------
    // Parameter sets
    // ----------------------------------------------------------------
    param_set_store sets (
        .clock(clock),
        .reset_n(reset_n),
        .edit_set(edit_set_select[1:0] - 2'd1),
        .edit_idx(reg_addr[3:0]),
        .edit_wr(set_par_wr),
        .edit_wdata(reg_wdata),
        .edit_rdata(edit_rdata),
        .use_set(set_inputs),
        .use_idx(use_idx),
        .use_rdata(use_rdata),
        .copy_start(copy_go && copy_ok),
        .copy_swap(hund == 2'd2),
        .copy_src(tens[1:0] - 2'd1),
        .copy_dst(ones[1:0] - 2'd1),
        .copy_busy(copy_busy)
    );

    // ----------------------------------------------------------------
    // Read path: data one cycle after the strobe
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 16'h0000;
        case (reg_addr)
            `OFS_VIEW_A: next_rdata = scale_disp(view_a_raw);
            `OFS_VIEW_B: next_rdata = scale_disp(view_b_raw);
            `OFS_SEL_ONE: next_rdata = scale_disp(source_one_raw);
            `OFS_SEL_ONE_SRC: next_rdata = {7'h00, source_one};
            `OFS_SEL_TWO: next_rdata = scale_disp(source_two_raw);
            `OFS_SEL_TWO_SRC: next_rdata = {7'h00, source_two};
            `OFS_RUN_HOURS: next_rdata = run_hours;
            `OFS_KEY_LEVEL: next_rdata = {10'h000, key_level};
            `OFS_LIST_FILTER: next_rdata = {14'h0000, list_filter};
            `OFS_NV_CTRL: next_rdata = {11'h000, nv_write_control};
            `OFS_EDIT_SET: next_rdata = {13'h0000, edit_set_select};
            `OFS_COPY_CMD: next_rdata = {8'h00, set_copy_command};
            `OFS_ACTIVE_SET:
                next_rdata = {14'h0000, set_inputs} + 16'h0001;
            `OFS_NV_COUNT: next_rdata = nv_write_count;
            `OFS_STATUS: begin
                next_rdata[`ST_PARAM_SAVE] = prot && nv_write_control[0];
                next_rdata[`ST_PROC_SAVE] = prot &&
                    (nv_write_control >= 5'd10);
                next_rdata[`ST_JUMPER] = write_protect_jumper;
                next_rdata[`ST_COPY_BUSY] = copy_busy;
                next_rdata[`ST_REFUSED] = refused;
            end
            default: begin
                // Fault words and set words by high nibble
                if (reg_addr[7:4] == `OFS_FAULT_BASE) begin
                    next_rdata = fault_diag_words[reg_addr[3:0]];
                end else if (reg_addr[7:4] == `OFS_SETPAR_BASE) begin
                    next_rdata = edit_rdata;
                end
            end
        endcase
    end

    // Read data flop and the in-use word for the control core
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
            use_data <= 16'h0000;
        end else begin
            use_data <= use_rdata;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end
endmodule

// File: tb/ctrl_sva.sv
/* Port checker for drive_param_ctrl, bound at the foot.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
module ctrl_sva (
    input wire clock,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire write_protect_jumper,
    input wire nv_proc_req,
    input wire nv_param_write,
    input wire nv_proc_write,
    input wire [5:0] access_level,
    input wire func_req,
    input wire [5:0] func_code
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Key writes need no level, so they are the cause to watch
    wire key_wr = reg_wr && reg_addr == 8'h07;
    chk_key_grant: assert property (
        key_wr && reg_wdata == 16'h0014 |-> ##2 access_level == 6'h14)
        else $error("key level not granted");
    chk_key_range: assert property (
        key_wr && reg_wdata > 16'h0028 |=> ##1 $stable(access_level))
        else $error("key out of range taken");
    chk_level_set: assert property (
        access_level inside {6'h00, 6'h0a, 6'h14, 6'h1e, 6'h28})
        else $error("level not graded");
    chk_func_cause: assert property (func_req |-> $past(key_wr))
        else $error("trigger without key write");
    chk_func_code: assert property (
        func_req |-> func_code inside {[6'h0b:6'h13], [6'h15:6'h1c]})
        else $error("trigger code wrong");
    chk_jumper_block: assert property (
        $past(write_protect_jumper) |-> !nv_param_write && !nv_proc_write)
        else $error("write past jumper");
    chk_proc_cause: assert property (nv_proc_write |-> $past(nv_proc_req))
        else $error("process save unasked");
    chk_read_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside slot");
    cover property (func_req);
    cover property (nv_param_write);
    cover property (nv_proc_write);
endmodule
bind drive_param_ctrl ctrl_sva chk (.clock, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .write_protect_jumper,
    .nv_proc_req, .nv_param_write, .nv_proc_write, .access_level,
    .func_req, .func_code);

// File: tb/panel_host.sv
/* Operator panel model: one-cycle register strobes.
   Assumes the slave never stalls and answers reads a cycle late. */
`timescale 1ns/1ns
module panel_host (
    input wire clock,
    input wire [15:0] reg_rdata,
    output reg [7:0] reg_addr = 8'h00,
    output reg [15:0] reg_wdata = 16'h0000,
    output reg reg_wr = 1'b0,
    output reg reg_rd = 1'b0
);
    // Few writes, supply never cut after a copy
    task wr(input [7:0] a, input [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input [7:0] a, output [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

// File: tb/drive_param_ctrl_bench.sv
/* Bench for drive_param_ctrl driven by the panel model.
   Assumes a 10 MHz clock and a short tenth count. */
`timescale 1ns/1ns
module drive_param_ctrl_bench;
    logic clock = 0, reset_n = 0, fault_wr = 0, running = 0;
    logic write_protect_jumper = 0, nv_param_req = 0, nv_proc_req = 0;
    logic [15:0] raw = 0, d, c;
    wire [15:0] reg_rdata, reg_wdata;
    wire [7:0] reg_addr;
    wire reg_wr, reg_rd, nv_param_write, nv_proc_write, func_req;
    wire [5:0] func_code, lvl;
    int n_mismatch = 0, total_checks = 0, i;
    // Rows: address, write data, raw connector, expected read
    logic [55:0] rows [16] = '{56'h03_0005_0000_0000, 56'h07_0014_0000_0014,
        56'h03_0190_0000_0000, 56'h03_018f_4000_018f,
        56'h02_0000_4000_2710, 56'h04_0000_c000_d8f0,
        56'h00_0000_7fff_4e1f, 56'h01_0000_8000_b1e0,
        56'h09_000c_0000_000b, 56'h0a_0005_0000_0001,
        56'h06_0005_0000_0000, 56'h1f_0000_0000_1234,
        56'h0c_0000_0000_0003, 56'h ff_0000_0000_0000,
        56'h08_0000_0000_0000, 56'h07_0029_0000_0014};
    logic [23:0] defs [6] = '{24'h07_0000, 24'h08_0003, 24'h09_000b,
        24'h0a_0001, 24'h0b_000c, 24'h03_0000};
    panel_host h (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd);
    drive_param_ctrl #(.TENTH_CYCLES(10)) uut (.clock, .reset_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .view_a_raw(raw), .view_b_raw(raw), .source_one(), .source_two(),
        .source_one_raw(raw), .source_two_raw(raw), .fault_wr,
        .fault_idx(4'hf), .fault_data(16'h1234), .running,
        .write_protect_jumper, .nv_param_req, .nv_proc_req,
        .nv_param_write, .nv_proc_write, .list_filter(), .access_level(lvl),
        .func_req, .func_code, .set_inputs(2'h2), .use_idx(4'h0),
        .use_data());
    always #50 clock = ~clock;
    task check(input [15:0] seen, exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Both save requests together, jumper set in the same cycle
    task pulse(input j);
        @(posedge clock);
        write_protect_jumper <= j;
        nv_param_req <= 1'b1;
        nv_proc_req <= 1'b1;
        @(posedge clock);
        nv_param_req <= 1'b0;
        nv_proc_req <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock) fault_wr <= 1'b1;
        @(posedge clock) fault_wr <= 1'b0;
        for (i = 0; i < 16; i++) begin
            @(posedge clock) raw <= rows[i][31:16];
            h.wr(rows[i][55:48], rows[i][47:32]);
            h.rd(rows[i][55:48], d);
            check(d, rows[i][15:0], "register");
        end
        for (i = 11; i < 29; i++) begin
            h.wr(8'h07, i[15:0]);
            #1 check(func_req, i != 20, "func_req");
            if (i != 20) check(func_code, i[5:0], "func_code");
        end
        @(posedge clock) reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            h.rd(defs[i][23:16], d);
            check(d, defs[i][15:0], "default");
        end
        h.rd(8'h0d, c);
        pulse(1'b1);
        check(nv_param_write, 0, "param save");
        pulse(1'b0);
        check(nv_param_write, 1, "param save");
        check(nv_proc_write, 1, "proc save");
        h.rd(8'h0d, d);
        check(d, c + 16'h1, "save count");
        h.wr(8'h07, 16'h0014);
        h.wr(8'h20, 16'habcd);
        check(lvl, 16'h0014, "level");
        h.wr(8'h0b, 16'h0070);
        repeat (20) @(posedge clock);
        h.rd(8'h0b, d);
        check(d, 16'h000c, "copy cmd");
        h.wr(8'h0a, 16'h0002);
        h.wr(8'h20, 16'h1111);
        h.wr(8'h0b, 16'h00d4);
        repeat (20) @(posedge clock);
        h.rd(8'h20, d);
        check(d, 16'habcd, "set word");
        @(posedge clock) running <= 1'b1;
        h.wr(8'h0b, 16'h0070);
        h.rd(8'h0b, d);
        check(d, 16'h000c, "copy cmd");
        test_done;
    end
    initial begin
        #2000000;
        n_mismatch++;
        test_done;
    end
endmodule
